// ===== nps_pkg.sv
// constants shared by the nonvolatile protection and security block
// assumes a 16-bit cpu address space and 8-bit register port
package nps_pkg;
    // register port indices
    localparam logic [1:0] REG_CFG  = 2'h0;
    localparam logic [1:0] REG_PROT = 2'h1;
    localparam logic [1:0] REG_OPT  = 2'h2;
    localparam logic [1:0] REG_STAT = 2'h3;
    // configuration register fields
    localparam int CFG_PAGE_SEL  = 0;
    localparam int CFG_KEY_ACC   = 1;
    localparam int CFG_DBG_REQ   = 2;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // working protection register: eeprom field [7:6], flash field [5:0]
    localparam int PROT_EPS_LSB = 6;
    localparam int PROT_FPS_MSB = 5;
    localparam int FPS_UNIT_SHIFT = 9;
    localparam int EPS_UNIT_SHIFT = 5;
    // option byte fields
    localparam int OPT_BACKDOOR_KEY_ENABLE  = 7;
    localparam int OPT_NORED  = 6;
    localparam int OPT_SECMOD = 5;
    localparam logic [1:0] SEC_OPEN = 2'h2;
    localparam logic [7:0] PROT_RESET = 8'h00;
    localparam logic [7:0] OPT_RESET  = 8'hff;
    // status register fields
    localparam int STAT_SECURE = 0;
    localparam int STAT_BDM    = 1;
    localparam int STAT_UNLOCK = 2;
    // addresses
    localparam logic [15:0] NV_PROT_ADDR   = 16'hffbd;
    localparam logic [15:0] NV_OPT_ADDR    = 16'hffbf;
    localparam logic [15:0] KEY_ADDR       = 16'hffb0;
    localparam logic [15:0] VEC_LO         = 16'hffc0;
    localparam logic [15:0] VEC_HI         = 16'hfffd;
    localparam logic [15:0] VEC_BLOCK_LO   = 16'hfd00;
    localparam logic [15:0] DIRECT_PAGE_HI = 16'h007f;
    localparam logic [15:0] HIGH_PAGE_LO   = 16'h1800;
    localparam logic [15:0] HIGH_PAGE_HI   = 16'h18ff;
    localparam logic [15:0] EE_WIN_LO      = 16'h1400;
    localparam logic [15:0] EE_WIN_HI      = 16'h17ff;
    localparam logic [15:0] VEC_AREA       = 16'h0040;
    localparam int KEY_BYTES = 8;
    // cycles after reset release before the background pin is caught
    // three synchroniser stages plus agreement, so the strap settles on edge four
    localparam logic [2:0] STRAP_WAIT = 3'h5;
endpackage

// ===== nps_sync3.sv
// three-stage input synchroniser with agreement filter
// assumes the input may change at any time relative to clk
`timescale 1ns/100ps
`default_nettype none
module nps_sync3 #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic pinIn,
    output var  logic pinOut
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_r   <= RESET_VAL;
            s2_r   <= RESET_VAL;
            s3_r   <= RESET_VAL;
            pinOut <= RESET_VAL;
        end else begin
            s1_r <= pinIn;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                pinOut <= s3_r;
            end
        end
    end
endmodule // nps_sync3
`default_nettype wire

// ===== nps_key_cmp.sv
// backdoor key capture and comparison
// assumes key writes arrive already qualified by the caller
`timescale 1ns/100ps
`default_nettype none
module nps_key_cmp
    import nps_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        keyAccess,
    input  wire logic        keyWr,
    input  wire logic [2:0]  keyIdx,
    input  wire logic [7:0]  keyByte,
    input  wire logic [63:0] nvKey,
    output var  logic        keyMatch
);
    logic [7:0] keyMem_r [KEY_BYTES];
    logic [3:0] count_r;
    logic       ordered_r;
    logic       keyAccDly_r;
    logic       allEqual;
    always_comb begin
        allEqual = 1'b1;
        for (int i = 0; i < KEY_BYTES; i++) begin
            if (keyMem_r[i] != nvKey[8*i +: 8]) begin
                allEqual = 1'b0;
            end
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_r     <= 4'h0;
            ordered_r   <= 1'b1;
            keyAccDly_r <= 1'b0;
            keyMatch    <= 1'b0;
            for (int i = 0; i < KEY_BYTES; i++) begin
                keyMem_r[i] <= 8'h00;
            end
        end else begin
            keyAccDly_r <= keyAccess;
            keyMatch    <= 1'b0;
            if (keyAccess && !keyAccDly_r) begin
                count_r   <= 4'h0;
                ordered_r <= 1'b1;
            end else if (keyWr) begin
                keyMem_r[keyIdx] <= keyByte;
                // out-of-order entry spoils the attempt
                if ({1'b0, keyIdx} != count_r[3:0] || count_r[3]) begin
                    ordered_r <= 1'b0;
                end
                if (!count_r[3]) begin
                    count_r <= count_r + 4'h1;
                end
            end
            if (!keyAccess && keyAccDly_r) begin
                keyMatch <= ordered_r && count_r[3] && allEqual;
            end
        end
    end
endmodule // nps_key_cmp
`default_nettype wire

// ===== nps_protect.sv
// nonvolatile memory protection, vector redirection, security and eeprom paging
// assumes the flash array presents its nonvolatile bytes and key at reset release,
// and that memory answers a read in the same cycle memReq is high
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - load protection register from nonvolatile byte
// - refuse program or erase in protected region
// - ignore protection writes shrinking protected region
// - protection register writable only by debug
// - redirect only when no-redirect bit zero
// - redirect only when some flash protected
// - redirect interrupt vectors, never reset vector
// - secure: unsecured or debug access blocked
// - register pages, debug, secure code stay open
// - copy nonvolatile option byte at reset
// - only security code 1:0 disengages security
// - no debug enable when secure; strap background
// - key enable zero forbids key unlock
// - key access captures key writes
// - matching key sets security field open
// - key writes only from secure code
// - erased blank check disengages security
// - protecting top block protects key, options
// - page select shows one eeprom half
// - 4-byte mode splits sector; erase both
// - 8-byte mode whole sector per page
module nps_protect
    import nps_pkg::*;
#(
    parameter int EE_ADDR_W = 10
) (
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    input  wire logic [7:0]           nvProtByte,
    input  wire logic [7:0]           nvOptByte,
    input  wire logic [63:0]          nvKey,
    input  wire logic                 backgroundPin,
    input  wire logic [1:0]           regAddr,
    input  wire logic [7:0]           regWdata,
    input  wire logic                 regWr,
    input  wire logic                 regRd,
    input  wire logic                 regFromDebug,
    output var  logic [7:0]           regRdata,
    input  wire logic                 cpuReq,
    input  wire logic                 cpuWr,
    input  wire logic [15:0]          cpuAddr,
    input  wire logic [7:0]           cpuWdata,
    input  wire logic                 cpuFromSecure,
    input  wire logic                 cpuFromDebug,
    output var  logic [7:0]           cpuRdata,
    output var  logic                 cpuRvalid,
    output var  logic                 memReq,
    output var  logic                 memWr,
    output var  logic [15:0]          memAddr,
    output var  logic [7:0]           memWdata,
    output var  logic [EE_ADDR_W:0]   eePhysAddr,
    input  wire logic [7:0]           memRdata,
    input  wire logic                 peReq,
    input  wire logic [15:0]          peAddr,
    input  wire logic                 peErase,
    output var  logic                 peGrant,
    output var  logic                 peRefused,
    output var  logic                 peEraseBothPages,
    input  wire logic                 blankDone,
    input  wire logic                 blankErased,
    input  wire logic                 vecReq,
    input  wire logic [15:0]          vecAddr,
    output var  logic                 vecAck,
    output var  logic [15:0]          vecPhysAddr,
    input  wire logic                 dbgEnableReq,
    output var  logic                 dbgEnable,
    output var  logic                 bdmActive,
    output var  logic                 secure
);
    logic [7:0]  cfg_r;
    logic [7:0]  prot_r;
    logic [7:0]  opt_r;
    logic [5:0]  nvFps_r;
    logic        loaded_r;
    logic [2:0]  strapCnt_r;
    logic        unlocked_r;
    logic        rdPend_r;
    logic        rdBlocked_r;
    logic        bkgdSync;
    logic        keyMatch;

    // field views
    wire logic [1:0]  epsCur     = prot_r[7:PROT_EPS_LSB];
    wire logic [5:0]  fpsCur     = prot_r[PROT_FPS_MSB:0];
    wire logic [1:0]  epsNew     = regWdata[7:PROT_EPS_LSB];
    wire logic [5:0]  fpsNew     = regWdata[PROT_FPS_MSB:0];
    wire logic        keyEnable  = opt_r[OPT_BACKDOOR_KEY_ENABLE];
    wire logic        noRedirect = opt_r[OPT_NORED];
    wire logic        sectorMode = opt_r[OPT_SECMOD];
    wire logic        pageSel    = cfg_r[CFG_PAGE_SEL];
    wire logic        keyAccess  = cfg_r[CFG_KEY_ACC];

    // security state
    wire logic secureNow = (opt_r[1:0] != SEC_OPEN);

    // protected region start: 512-byte units counted down from the top
    wire logic [16:0] flashSpan  = {5'h00, fpsCur, 6'h00} << (FPS_UNIT_SHIFT - 6);
    wire logic [15:0] flashStart = 16'(17'h10000 - flashSpan);
    wire logic [16:0] nvSpan     = {5'h00, nvFps_r, 6'h00} << (FPS_UNIT_SHIFT - 6);
    wire logic [15:0] nvStart    = 16'(17'h10000 - nvSpan);
    wire logic [EE_ADDR_W:0] eeSpan = (EE_ADDR_W+1)'(({1'b0, epsCur} == 3'h0) ? 0
                                    : (32'h1 << (EPS_UNIT_SHIFT + {30'h0, epsCur})));

    // address classes
    wire logic inDirect   = (cpuAddr <= DIRECT_PAGE_HI);
    wire logic inHighPage = (cpuAddr >= HIGH_PAGE_LO) && (cpuAddr <= HIGH_PAGE_HI);
    wire logic cpuSecRes  = !inDirect && !inHighPage;
    wire logic cpuIsKey   = (cpuAddr[15:3] == KEY_ADDR[15:3]);
    wire logic cpuInEe    = (cpuAddr >= EE_WIN_LO) && (cpuAddr <= EE_WIN_HI);
    wire logic peInEe     = (peAddr >= EE_WIN_LO) && (peAddr <= EE_WIN_HI);

    // access gating
    wire logic cpuTrusted = cpuFromSecure && !cpuFromDebug;
    wire logic cpuBlocked = secureNow && cpuSecRes && !cpuTrusted;
    wire logic cpuOpen    = !cpuBlocked;
    wire logic keyWrite   = cpuReq && cpuWr && cpuIsKey && keyAccess
                          && keyEnable && cpuTrusted;
    wire logic keyAbsorb  = cpuReq && cpuWr && cpuIsKey && keyAccess;
    wire logic cpuPass    = cpuReq && cpuOpen && !keyAbsorb;

    // eeprom page mapping of the visible half
    wire logic [EE_ADDR_W-1:0] cpuEeOff = cpuAddr[EE_ADDR_W-1:0];
    wire logic [EE_ADDR_W-1:0] peEeOff  = peAddr[EE_ADDR_W-1:0];
    wire logic [EE_ADDR_W:0] cpuEePhys = sectorMode
        ? {pageSel, cpuEeOff}
        : {cpuEeOff[EE_ADDR_W-1:2], pageSel, cpuEeOff[1:0]};
    wire logic [EE_ADDR_W:0] peEePhys = sectorMode
        ? {pageSel, peEeOff}
        : {peEeOff[EE_ADDR_W-1:2], pageSel, peEeOff[1:0]};

    // program and erase protection
    wire logic [EE_ADDR_W:0] eeTopOff = (EE_ADDR_W+1)'({1'b0, {EE_ADDR_W{1'b1}}});
    wire logic peEeProt  = (eeSpan != '0) && ({1'b0, peEeOff} > (eeTopOff - eeSpan));
    wire logic peFlProt  = (fpsCur != 6'h00) && ((peAddr >= flashStart)
                         || (peAddr >= VEC_BLOCK_LO));
    wire logic peBlocked = peInEe ? peEeProt : peFlProt;

    // working protection writes
    wire logic protWrite  = regWr && (regAddr == REG_PROT) && regFromDebug;
    wire logic protShrink = (fpsNew < fpsCur) || (epsNew < epsCur);
    wire logic cfgWrite   = regWr && (regAddr == REG_CFG);

    // vector redirection
    wire logic redirOn   = !noRedirect && (nvFps_r != 6'h00);
    wire logic vecInIrq  = (vecAddr >= VEC_LO) && (vecAddr <= VEC_HI);
    wire logic [15:0] vecRedir = (nvStart - VEC_AREA) | {10'h000, vecAddr[5:0]};
    wire logic [15:0] vecNext  = (redirOn && vecInIrq) ? vecRedir : vecAddr;

    // register read mux
    wire logic [7:0] statView = {5'h00, unlocked_r, bdmActive, secure};
    wire logic [7:0] rdMux = (regAddr == REG_CFG)  ? cfg_r
                           : (regAddr == REG_PROT) ? prot_r
                           : (regAddr == REG_OPT)  ? opt_r
                           : statView;

    nps_sync3 #(
        .RESET_VAL (1'b1)
    ) u_background_pin_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .pinIn  (backgroundPin),
        .pinOut (bkgdSync)
    );

    nps_key_cmp u_key (
        .clk       (clk),
        .arst_n    (arst_n),
        .keyAccess (keyAccess),
        .keyWr     (keyWrite),
        .keyIdx    (cpuAddr[2:0]),
        .keyByte   (cpuWdata),
        .nvKey     (nvKey),
        .keyMatch  (keyMatch)
    );

    // nonvolatile loading and protection register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            loaded_r <= 1'b0;
            prot_r   <= PROT_RESET;
            nvFps_r  <= 6'h00;
        end else if (!loaded_r) begin
            loaded_r <= 1'b1;
            prot_r   <= nvProtByte;
            nvFps_r  <= nvProtByte[PROT_FPS_MSB:0];
        end else if (protWrite && !protShrink) begin
            prot_r <= regWdata;
        end
    end

    // option register and unlocking; unlock sticks until reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            opt_r      <= OPT_RESET;
            unlocked_r <= 1'b0;
        end else if (!loaded_r) begin
            opt_r <= nvOptByte;
        end else if ((keyMatch && keyEnable) || (blankDone && blankErased)) begin
            opt_r[1:0] <= SEC_OPEN;
            unlocked_r <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r <= CFG_RESET;
        end else if (cfgWrite) begin
            cfg_r <= {5'h00, regWdata[CFG_DBG_REQ:0]};
        end
    end

    // background strap caught once the synchroniser has filled
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            strapCnt_r <= 3'h0;
            bdmActive  <= 1'b0;
        end else if (strapCnt_r != STRAP_WAIT) begin
            strapCnt_r <= strapCnt_r + 3'h1;
            if (strapCnt_r == STRAP_WAIT - 3'h1) begin
                bdmActive <= !bkgdSync;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            secure    <= 1'b1;
            dbgEnable <= 1'b0;
            regRdata  <= 8'h00;
        end else begin
            secure    <= secureNow;
            dbgEnable <= dbgEnableReq && cfg_r[CFG_DBG_REQ] && !secureNow;
            regRdata  <= regRd ? rdMux : 8'h00;
        end
    end

    // memory request path; blocked writes never reach memory
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            memReq     <= 1'b0;
            memWr      <= 1'b0;
            memAddr    <= 16'h0000;
            memWdata   <= 8'h00;
            eePhysAddr <= '0;
        end else begin
            memReq     <= cpuPass;
            memWr      <= cpuPass && cpuWr;
            memAddr    <= cpuAddr;
            memWdata   <= cpuWdata;
            eePhysAddr <= cpuInEe ? cpuEePhys : '0;
        end
    end

    // read answer: memory data two cycles after the request, zero when blocked
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdPend_r    <= 1'b0;
            rdBlocked_r <= 1'b0;
            cpuRvalid   <= 1'b0;
            cpuRdata    <= 8'h00;
        end else begin
            rdPend_r    <= cpuReq && !cpuWr;
            rdBlocked_r <= cpuBlocked;
            cpuRvalid   <= rdPend_r;
            cpuRdata    <= (rdPend_r && !rdBlocked_r) ? memRdata : 8'h00;
        end
    end

    // program and erase gate
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            peGrant          <= 1'b0;
            peRefused        <= 1'b0;
            peEraseBothPages <= 1'b0;
        end else begin
            peGrant          <= peReq && !peBlocked;
            peRefused        <= peReq && peBlocked;
            peEraseBothPages <= peReq && !peBlocked && peErase && peInEe
                              && !sectorMode && (peEePhys[2] == pageSel);
        end
    end

    // vector fetch translation
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            vecAck      <= 1'b0;
            vecPhysAddr <= 16'h0000;
        end else begin
            vecAck      <= vecReq;
            vecPhysAddr <= vecNext;
        end
    end
endmodule // nps_protect
`default_nettype wire

// ===== nps_protect_asserts.sv
// port-level assertions for the protection and security block
// assumes binding to nps_protect, one clock domain
`timescale 1ns/100ps
`default_nettype none
module nps_protect_asserts (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        cpuReq,
    input wire logic        cpuWr,
    input wire logic [15:0] cpuAddr,
    input wire logic        cpuFromSecure,
    input wire logic        cpuFromDebug,
    input wire logic [7:0]  cpuRdata,
    input wire logic        cpuRvalid,
    input wire logic        memReq,
    input wire logic [15:0] memAddr,
    input wire logic        peReq,
    input wire logic        peGrant,
    input wire logic        peRefused,
    input wire logic        blankDone,
    input wire logic        blankErased,
    input wire logic        vecReq,
    input wire logic [15:0] vecAddr,
    input wire logic        vecAck,
    input wire logic [15:0] vecPhysAddr,
    input wire logic        dbgEnable,
    input wire logic        secure
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_rd_req;
        cpuReq && !cpuWr;
    endsequence
    // debug access outside register pages while locked
    sequence s_blocked;
        secure && cpuReq && cpuFromDebug && cpuAddr[15:7] != 9'h0 && cpuAddr[15:8] != 8'h18;
    endsequence
    a_read_answer: assert property (s_rd_req |=> ##1 cpuRvalid)
        else $error("cpu read not answered");
    a_blocked_drop: assert property (s_blocked |=> !memReq)
        else $error("blocked access reached memory");
    a_blocked_zero: assert property (s_blocked ##0 !cpuWr |=> ##1 (cpuRvalid && cpuRdata == 8'h00))
        else $error("blocked read not zero");
    a_secure_open: assert property (s_rd_req ##0 (cpuFromSecure && !cpuFromDebug)
                                    |=> memReq && memAddr == $past(cpuAddr))
        else $error("secure read not passed");
    a_pe_answer: assert property (peReq |=> peGrant != peRefused)
        else $error("pe request without one answer");
    a_vec_reset: assert property (vecReq && vecAddr >= 16'hfffe |=> vecAck && vecPhysAddr == $past(vecAddr))
        else $error("reset vector fetch was moved");
    a_vec_offset: assert property (vecReq && vecAddr inside {[16'hffc0:16'hfffd]}
                                   |=> vecPhysAddr[5:0] == $past(vecAddr[5:0]))
        else $error("vector offset not kept");
    a_dbg_locked: assert property (secure |-> !dbgEnable)
        else $error("debug module enabled while secure");
    a_blank_open: assert property (blankDone && blankErased |-> ##[1:2] !secure)
        else $error("blank check left device secure");
    a_open_sticky: assert property (!secure |=> !secure)
        else $error("security engaged again");
endmodule // nps_protect_asserts
bind nps_protect nps_protect_asserts u_asserts (.*);
`default_nettype wire

// ===== nps_mem_model.sv
// memory array seen behind the protection block
// assumes reads are answered in the cycle memReq is high
`timescale 1ns/100ps
`default_nettype none
module nps_mem_model (
    input  wire logic        clk,
    input  wire logic        memReq,
    input  wire logic        memWr,
    input  wire logic [15:0] memAddr,
    input  wire logic [7:0]  memWdata,
    output wire logic [7:0]  memRdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] lastQ = 8'h00;
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'(i) ^ 8'(i >> 8);
        end
    end
    // idle bus shows the inverse, so a stale byte never passes for data
    assign memRdata = (memReq && !memWr) ? mem[memAddr] : ~lastQ;
    always @(posedge clk) begin
        if (memReq && memWr) begin
            mem[memAddr] <= memWdata;
        end
        lastQ <= memRdata;
    end
endmodule // nps_mem_model
`default_nettype wire

// ===== test_nvm_protect_security.sv
// self-checking bench for the protection and security block
// assumes memory model content byte = addr high ^ addr low
`timescale 1ns/100ps
`default_nettype none
module test_nvm_protect_security
    import nps_pkg::*;
;
    localparam logic [1:0] S_APP = 2'h0, S_SEC = 2'h1, S_DBG = 2'h2;
    logic        clk = 1'b0, arst_n = 1'b0, backgroundPin = 1'b0;
    logic [7:0]  nvProtByte = 8'h00, nvOptByte = 8'h00, regWdata = 8'h00, cpuWdata = 8'h00;
    logic [63:0] nvKey = 64'h0123456789abcdef;
    logic [1:0]  regAddr = 2'h0;
    logic        regWr = 1'b0, regRd = 1'b0, regFromDebug = 1'b0, cpuReq = 1'b0, cpuWr = 1'b0;
    logic        cpuFromSecure = 1'b0, cpuFromDebug = 1'b0, peReq = 1'b0, peErase = 1'b0;
    logic        blankDone = 1'b0, blankErased = 1'b0, vecReq = 1'b0, dbgEnableReq = 1'b0;
    logic [15:0] cpuAddr = 16'h0000, peAddr = 16'h0000, vecAddr = 16'h0000;
    logic [7:0]  regRdata, cpuRdata, memWdata, memRdata;
    logic [15:0] memAddr, vecPhysAddr, resQ, memQ, eeQ;
    logic [10:0] eePhysAddr;
    logic        cpuRvalid, memReq, memWr, peGrant, peRefused, peEraseBothPages;
    logic        vecAck, dbgEnable, bdmActive, secure;
    int          errTotal = 0, totalChecks = 0;
    always #10 clk = ~clk;
    nps_protect #(.EE_ADDR_W(10)) DUT (.*);
    nps_mem_model u_mem (.*);
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", totalChecks, errTotal);
        if (errTotal == 0 && totalChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic rst(input logic [7:0] p, input logic [7:0] o, input logic pin);
        @(posedge clk);
        arst_n <= 1'b0;
        nvProtByte <= p;
        nvOptByte <= o;
        backgroundPin <= pin;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
    endtask
    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d, input logic dbg);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regFromDebug <= dbg;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic reg_chk(input logic [1:0] a, input logic [7:0] mask, input logic [7:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 check({8'h00, regRdata & mask}, {8'h00, exp});
    endtask
    // writes are judged by memReq, reads by {valid, data}
    task automatic cpu_chk(input logic wr, input logic [15:0] a, input logic [7:0] d, input logic [1:0] src,
                           input logic [15:0] exp);
        @(posedge clk);
        cpuReq <= 1'b1;
        cpuWr <= wr;
        cpuAddr <= a;
        cpuWdata <= d;
        cpuFromDebug <= src[1];
        cpuFromSecure <= src[0];
        @(posedge clk);
        cpuReq <= 1'b0;
        #1 memQ = {15'h0, memReq};
        eeQ = {5'h0, eePhysAddr};
        @(posedge clk);
        #1 resQ = {7'h0, cpuRvalid, cpuRdata};
        check(wr ? memQ : resQ, exp);
    endtask
    task automatic pe_chk(input logic [15:0] a, input logic er, input logic [15:0] exp);
        @(posedge clk);
        peReq <= 1'b1;
        peAddr <= a;
        peErase <= er;
        @(posedge clk);
        peReq <= 1'b0;
        #1 check({13'h0, peEraseBothPages, peRefused, peGrant}, exp);
    endtask
    task automatic vec_chk(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk);
        vecReq <= 1'b1;
        vecAddr <= a;
        @(posedge clk);
        vecReq <= 1'b0;
        #1 check(vecPhysAddr, exp);
    endtask
    // two spare cycles between key writes, never adjacent
    task automatic key_try(input logic [1:0] src, input logic [7:0] flip, input logic expSecure);
        reg_wr(REG_CFG, 8'h02, 1'b0);
        for (int i = 0; i < KEY_BYTES; i++) begin
            cpu_chk(1'b1, KEY_ADDR + 16'(i), nvKey[8*i +: 8] ^ ((i == 7) ? flip : 8'h00), src, 16'h0000);
        end
        reg_wr(REG_CFG, 8'h00, 1'b0);
        repeat (4) @(posedge clk);
        #1 check({15'h0, secure}, {15'h0, expSecure});
    endtask
    task automatic blank(input logic ok);
        @(posedge clk);
        blankDone <= 1'b1;
        blankErased <= ok;
        @(posedge clk);
        blankDone <= 1'b0;
        repeat (3) @(posedge clk);
        #1 check({15'h0, secure}, {15'h0, !ok});
    endtask
    task automatic test_regs();
        check({15'h0, bdmActive}, 16'h0001);
        reg_chk(REG_PROT, 8'hff, 8'h03);
        reg_wr(REG_OPT, 8'h00, 1'b1);
        reg_chk(REG_OPT, 8'hff, 8'h83);
        reg_chk(REG_STAT, 8'h01, 8'h01);
        reg_wr(REG_PROT, 8'h3f, 1'b0);
        reg_chk(REG_PROT, 8'hff, 8'h03);
        reg_wr(REG_PROT, 8'h01, 1'b1);
        reg_chk(REG_PROT, 8'hff, 8'h03);
        reg_wr(REG_PROT, 8'h47, 1'b1);
        reg_chk(REG_PROT, 8'hff, 8'h47);
        $display("test regs done");
    endtask
    task automatic test_pe_vec();
        pe_chk(16'hf200, 1'b0, 16'h0002);
        pe_chk(16'hf1ff, 1'b0, 16'h0001);
        pe_chk(16'h17c0, 1'b1, 16'h0002);
        pe_chk(16'h1400, 1'b1, 16'h0005);
        vec_chk(16'hffe0, 16'hf9e0);
        vec_chk(16'hffc0, 16'hf9c0);
        vec_chk(16'hfffd, 16'hf9fd);
        vec_chk(16'hfffe, 16'hfffe);
        $display("test pe_vec done");
    endtask
    task automatic test_sec();
        @(posedge clk);
        dbgEnableReq <= 1'b1;
        cpu_chk(1'b0, 16'h1405, 8'h00, S_DBG, 16'h0100);
        cpu_chk(1'b0, 16'h2000, 8'h00, S_APP, 16'h0100);
        cpu_chk(1'b1, 16'h2000, 8'h55, S_APP, 16'h0000);
        cpu_chk(1'b0, 16'h2000, 8'h00, S_SEC, 16'h0120);
        cpu_chk(1'b0, 16'h0010, 8'h00, S_DBG, 16'h0110);
        cpu_chk(1'b0, 16'h1810, 8'h00, S_DBG, 16'h0108);
        cpu_chk(1'b0, 16'h1405, 8'h00, S_SEC, 16'h0111);
        check(eeQ, 16'h0009);
        reg_wr(REG_CFG, 8'h01, 1'b0);
        cpu_chk(1'b0, 16'h1405, 8'h00, S_SEC, 16'h0111);
        check(eeQ, 16'h000d);
        check({15'h0, dbgEnable}, 16'h0000);
        key_try(S_DBG, 8'h00, 1'b1);
        key_try(S_SEC, 8'h01, 1'b1);
        key_try(S_SEC, 8'h00, 1'b0);
        reg_chk(REG_OPT, 8'h03, 8'h02);
        reg_wr(REG_CFG, 8'h04, 1'b0);
        cpu_chk(1'b0, 16'h1405, 8'h00, S_DBG, 16'h0111);
        check({15'h0, dbgEnable}, 16'h0001);
        $display("test sec done");
    endtask
    task automatic test_codes();
        for (int c = 0; c < 4; c++) begin
            rst(8'h03, 8'h40 | 8'(c), 1'b1);
            check({15'h0, secure}, {15'h0, c != 2});
            vec_chk(16'hffe0, 16'hffe0);
        end
        check({15'h0, bdmActive}, 16'h0000);
        $display("test codes done");
    endtask
    task automatic test_nokey();
        rst(8'h00, 8'h23, 1'b1);
        vec_chk(16'hffe0, 16'hffe0);
        key_try(S_SEC, 8'h00, 1'b1);
        cpu_chk(1'b0, 16'h1405, 8'h00, S_SEC, 16'h0111);
        check(eeQ, 16'h0005);
        reg_wr(REG_CFG, 8'h01, 1'b0);
        cpu_chk(1'b0, 16'h1405, 8'h00, S_SEC, 16'h0111);
        check(eeQ, 16'h0405);
        pe_chk(16'h1400, 1'b1, 16'h0001);
        reg_wr(REG_PROT, 8'h01, 1'b1);
        pe_chk(16'hfd00, 1'b0, 16'h0002);
        pe_chk(16'hfcff, 1'b0, 16'h0001);
        blank(1'b0);
        blank(1'b1);
        $display("test nokey done");
    endtask
    // ~310 cycles expected, margin over a hundredfold
    initial begin
        #1000000;
        errTotal++;
        tally_and_finish();
    end
    initial begin
        rst(8'h03, 8'h83, 1'b0);
        test_regs();
        test_pe_vec();
        test_sec();
        test_codes();
        test_nokey();
        tally_and_finish();
    end
endmodule // test_nvm_protect_security
`default_nettype wire
